// [src/tmac_map.svh]
// Register offsets, field positions and reset values of the timer match action block
`ifndef TMAC_MAP_SVH
`define TMAC_MAP_SVH
// Byte offsets of the registers (address bits 7:0)
`define TMAC_OFF_CTRL 8'h00
`define TMAC_OFF_TC 8'h04
`define TMAC_OFF_PSLIM 8'h08
`define TMAC_OFF_PC 8'h0C
`define TMAC_OFF_MCTRL 8'h10
`define TMAC_OFF_MV2 8'h14
`define TMAC_OFF_MV3 8'h18
`define TMAC_OFF_MV4 8'h1C
`define TMAC_OFF_CMSEL 8'h20
// Control register fields
`define TMAC_CTRL_RUN 0
`define TMAC_CTRL_CLR 1
// Match control layout: three bits per channel, channel 2 first
`define TMAC_MC_BASE 6
`define TMAC_MC_STRIDE 3
`define TMAC_MC_IRQ 0
`define TMAC_MC_CLR 1
`define TMAC_MC_HALT 2
`define TMAC_NCH 3
// Condition select width
`define TMAC_CM_W 3
// Reset value of every register
`define TMAC_RST_WORD 32'h0000_0000
// Bus encodings
`define TMAC_HTRANS_BUSY_BIT 1
`define TMAC_HRESP_OKAY 1'b0
`endif

// [src/tmac_pkg.sv]
// Types shared by the timer match action block
`default_nettype none
package tmac_pkg;
  // Captured AHB address phase
  typedef struct packed {
    logic sel;
    logic wr;
    logic [7:0] off;
  } tmac_aphase_s;
  // Per-channel action enables
  typedef struct packed {
    logic halt;
    logic clr;
    logic irq;
  } tmac_mact_s;
endpackage
`default_nettype wire

// [src/tmac_top.sv]
// Timer with per-channel match actions (channels 2 to 4) behind an AHB-Lite slave
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "tmac_map.svh"

module tmac_top
  import tmac_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int PS_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [`TMAC_NCH-1:0] match_irq,
  output logic [`TMAC_CM_W-1:0] irq_condition_select,
  output logic [CNT_W-1:0] timer_count,
  output logic count_run_flag
);
  localparam int NCH = `TMAC_NCH;
  // hsize is not decoded: every register is one word, so narrower transfers act as whole-word ones

  // Widths wider than a bus word cannot be read back, so elaboration refuses them
  if (CNT_W < 1 || CNT_W > 32 || PS_W < 1 || PS_W > 32) begin : gen_bad_width
    $error("tmac_top: CNT_W and PS_W must lie in 1..32");
  end
  // The match value offset table below is written for exactly three channels
  if (NCH != 3) begin : gen_bad_nch
    $error("tmac_top: the match value table serves three channels only");
  end

  // Bits of the match control word that hold storage
  function automatic logic [31:0] mc_mask();
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < NCH * `TMAC_MC_STRIDE; i++) begin
      m[`TMAC_MC_BASE + i] = 1'b1;
    end
    return m;
  endfunction

  localparam logic [31:0] MC_MASK = mc_mask();

  tmac_aphase_s ap_ff;
  logic [31:0] hrdata_ff;
  logic run_ff;
  logic [CNT_W-1:0] tc_ff;
  logic [PS_W-1:0] pc_ff;
  logic [PS_W-1:0] pslim_ff;
  logic [31:0] mctrl_ff;
  logic [CNT_W-1:0] mv_ff [NCH];
  logic [`TMAC_CM_W-1:0] cm_ff;
  logic [NCH-1:0] irq_ff;

  logic nxt_run;
  logic [CNT_W-1:0] nxt_tc;
  logic [PS_W-1:0] nxt_pc;
  logic [PS_W-1:0] nxt_pslim;
  logic [31:0] nxt_mctrl;
  logic [`TMAC_CM_W-1:0] nxt_cm;
  logic [31:0] nxt_rdata;
  tmac_aphase_s nxt_ap;

  // Address phase is taken when selected, ready and NONSEQ or SEQ (htrans bit 1); the slave never stalls
  wire take = hsel & hready & htrans[`TMAC_HTRANS_BUSY_BIT];
  assign nxt_ap = '{sel: take, wr: hwrite, off: haddr[7:0]};

  // Data-phase write strobes
  wire wr_now = ap_ff.sel & ap_ff.wr;
  wire wr_ctrl = wr_now && ap_ff.off == `TMAC_OFF_CTRL;
  wire wr_tc = wr_now && ap_ff.off == `TMAC_OFF_TC;
  wire wr_pslim = wr_now && ap_ff.off == `TMAC_OFF_PSLIM;
  wire wr_mctrl = wr_now && ap_ff.off == `TMAC_OFF_MCTRL;
  wire wr_cm = wr_now && ap_ff.off == `TMAC_OFF_CMSEL;
  wire sw_clr = wr_ctrl && hwdata[`TMAC_CTRL_CLR];
  // Any software access that owns the counter this cycle
  wire sw_cnt = wr_ctrl | wr_tc;

  // Unpack the enables of each channel
  tmac_mact_s act [NCH];
  logic [NCH-1:0] hit;
  logic [NCH-1:0] halt_en;
  logic [NCH-1:0] clr_en;
  logic [NCH-1:0] ie_en;
  logic [CNT_W-1:0] nxt_mv [NCH];

  // The prescaler wraps once per count step; matches are judged on that step
  // A limit of zero makes every clock a count step; a larger limit slows matching alike
  wire tick = run_ff && pc_ff == pslim_ff;

  localparam logic [7:0] MV_OFF [NCH] = '{`TMAC_OFF_MV2, `TMAC_OFF_MV3, `TMAC_OFF_MV4};

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      localparam int B = `TMAC_MC_BASE + g * `TMAC_MC_STRIDE;
      // Channel action bits from the match control word
      assign act[g] = '{halt: mctrl_ff[B + `TMAC_MC_HALT], clr: mctrl_ff[B + `TMAC_MC_CLR],
                        irq: mctrl_ff[B + `TMAC_MC_IRQ]};
      assign halt_en[g] = act[g].halt;
      assign clr_en[g] = act[g].clr;
      assign ie_en[g] = act[g].irq;
      // A channel hits on a count step while the count equals its match value
      assign hit[g] = tick && tc_ff == mv_ff[g];
      assign nxt_mv[g] = (wr_now && ap_ff.off == MV_OFF[g]) ? hwdata[CNT_W-1:0] : mv_ff[g];

      // Match value storage
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mv_ff[g] <= CNT_W'(`TMAC_RST_WORD);
        end else begin
          mv_ff[g] <= nxt_mv[g];
        end
      end
    end
  endgenerate

  // Halt outranks clear when both are armed on a matching channel
  wire any_halt = |(hit & halt_en);
  wire any_clr = |(hit & clr_en) & ~any_halt;

  // Counter next state; a software write wins over a same-cycle match action
  assign nxt_tc = wr_tc ? hwdata[CNT_W-1:0] :
                  sw_clr ? '0 :
                  any_halt ? tc_ff :
                  any_clr ? '0 :
                  tick ? tc_ff + CNT_W'(1) : tc_ff;
  assign nxt_pc = sw_clr ? '0 :
                  any_halt ? pc_ff :
                  tick ? '0 :
                  run_ff ? pc_ff + PS_W'(1) : pc_ff;
  assign nxt_run = wr_ctrl ? hwdata[`TMAC_CTRL_RUN] : (run_ff & ~any_halt);
  assign nxt_pslim = wr_pslim ? hwdata[PS_W-1:0] : pslim_ff;
  assign nxt_mctrl = wr_mctrl ? (hwdata & MC_MASK) : mctrl_ff;
  assign nxt_cm = wr_cm ? hwdata[`TMAC_CM_W-1:0] : cm_ff;

  // Read mux looks at next values so a read right behind a write sees the new data
  always_comb begin
    nxt_rdata = `TMAC_RST_WORD;
    if (take && !hwrite) begin
      case (haddr[7:0])
        `TMAC_OFF_CTRL: nxt_rdata[`TMAC_CTRL_RUN] = nxt_run;
        `TMAC_OFF_TC: nxt_rdata[CNT_W-1:0] = nxt_tc;
        `TMAC_OFF_PSLIM: nxt_rdata[PS_W-1:0] = nxt_pslim;
        `TMAC_OFF_PC: nxt_rdata[PS_W-1:0] = nxt_pc;
        `TMAC_OFF_MCTRL: nxt_rdata = nxt_mctrl;
        `TMAC_OFF_MV2: nxt_rdata[CNT_W-1:0] = nxt_mv[0];
        `TMAC_OFF_MV3: nxt_rdata[CNT_W-1:0] = nxt_mv[1];
        `TMAC_OFF_MV4: nxt_rdata[CNT_W-1:0] = nxt_mv[2];
        `TMAC_OFF_CMSEL: nxt_rdata[`TMAC_CM_W-1:0] = nxt_cm;
        default: nxt_rdata = `TMAC_RST_WORD;
      endcase
    end
  end

  // Bus-side registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ap_ff <= '0;
      hrdata_ff <= `TMAC_RST_WORD;
    end else begin
      ap_ff <= nxt_ap;
      hrdata_ff <= nxt_rdata;
    end
  end

  // Configuration registers; every enable starts cleared
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mctrl_ff <= `TMAC_RST_WORD;
      pslim_ff <= PS_W'(`TMAC_RST_WORD);
      cm_ff <= `TMAC_CM_W'(`TMAC_RST_WORD);
    end else begin
      mctrl_ff <= nxt_mctrl;
      pslim_ff <= nxt_pslim;
      cm_ff <= nxt_cm;
    end
  end

  // Counter core
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_ff <= 1'b0;
      tc_ff <= CNT_W'(`TMAC_RST_WORD);
      pc_ff <= PS_W'(`TMAC_RST_WORD);
    end else begin
      run_ff <= nxt_run;
      tc_ff <= nxt_tc;
      pc_ff <= nxt_pc;
    end
  end

  // One-cycle interrupt pulses; condition shaping is left to the interrupt controller
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_ff <= '0;
    end else begin
      irq_ff <= hit & ie_en;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = `TMAC_HRESP_OKAY;
  assign hrdata = hrdata_ff;
  assign match_irq = irq_ff;
  assign irq_condition_select = cm_ff;
  assign timer_count = tc_ff;
  assign count_run_flag = run_ff;

  // Checks of the match actions; each looks one edge past the matching tick, where the action lands
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Software access wins over a same-cycle match action, so it is kept out of the antecedents

  // Interrupt pulses follow an enabled match by exactly one edge
  a_ch4_irq_raise: assert property ((match_irq[2] == $past(hit[2] && ie_en[2])) || $past(rst))
    else $error("channel 4 interrupt does not follow match and enable");
  a_ch4_irq_off: assert property ((hit[2] && !ie_en[2]) |=> !match_irq[2])
    else $error("channel 4 interrupt raised while disabled");
  a_ch3_irq_raise: assert property ((hit[1] && ie_en[1]) |=>
    match_irq[1] ##1 (!match_irq[1] || $past(hit[1] && ie_en[1])))
    else $error("channel 3 interrupt pulse wrong");
  a_ch3_irq_off: assert property ((hit[1] && !ie_en[1]) |=> !match_irq[1])
    else $error("channel 3 interrupt raised while disabled");
  a_irq_quiet_off: assert property ((!(|(hit & ie_en))) |=> match_irq == '0)
    else $error("interrupt without enabled match");

  // Halt freezes count and prescale count and drops the run flag
  a_ch3_halt_all: assert property ((hit[1] && halt_en[1] && !sw_cnt) |=>
    (!count_run_flag && timer_count == $past(tc_ff) && pc_ff == $past(pc_ff)))
    else $error("channel 3 halt did not stop the counter");
  a_ch2_halt_all: assert property ((hit[0] && halt_en[0] && !sw_cnt) |=>
    (!count_run_flag && $stable(tc_ff) && $stable(pc_ff)))
    else $error("channel 2 halt did not stop the counter");
  // Once halted, the count must not creep on until software restarts it
  a_halted_stays: assert property ((!run_ff && !sw_cnt) |=> ($stable(tc_ff) && $stable(pc_ff)))
    else $error("count moved while halted");

  // Clear zeroes the count but leaves the timer running; without clear the match leaves it alone
  a_ch3_clear_count: assert property ((hit[1] && clr_en[1] && !any_halt && !sw_cnt) |=>
    (timer_count == '0 && count_run_flag))
    else $error("channel 3 clear did not zero the count");
  a_ch3_clear_off: assert property ((hit[1] && !clr_en[1] && !any_halt && !any_clr && !sw_cnt) |=>
    timer_count == $past(tc_ff) + CNT_W'(1))
    else $error("channel 3 match moved the count although clear was off");
  a_ch2_clear_count: assert property ((hit[0] && clr_en[0] && !any_halt && !sw_cnt) |=>
    timer_count == '0)
    else $error("channel 2 clear did not zero the count");
  a_ch2_clear_off: assert property ((hit[0] && !clr_en[0] && !any_halt && !any_clr && !sw_cnt) |=>
    timer_count == $past(tc_ff) + CNT_W'(1))
    else $error("channel 2 match moved the count although clear was off");

  // Halt outranks clear: the count holds at the match value, unless software then rewrites it
  a_halt_over_clear: assert property ((|(hit & clr_en) && any_halt && !sw_cnt) |=>
    ($stable(tc_ff) && !count_run_flag) ##1 ($stable(tc_ff) || $past(sw_cnt)))
    else $error("clear acted although halt was armed");

  // Enable word: a written value lands, an unwritten word holds, unused bits stay zero
  a_enable_write_back: assert property (wr_mctrl |=> mctrl_ff == ($past(hwdata) & MC_MASK))
    else $error("match control word not stored");
  a_enable_hold: assert property (!wr_mctrl |=> $stable(mctrl_ff))
    else $error("match control word changed without a write");
  a_enable_unused_zero: assert property ((mctrl_ff & ~MC_MASK) == '0)
    else $error("match control word holds bits outside the channels");

  // Software control of the counter and the read path
  a_sw_count_load: assert property (wr_tc |=> timer_count == $past(hwdata[CNT_W-1:0]))
    else $error("timer count write not stored");
  a_sw_clear_count: assert property (sw_clr |=> (timer_count == '0 && pc_ff == '0))
    else $error("software clear did not zero the counts");
  a_psc_wrap: assert property ((tick && !sw_clr && !any_halt) |=> pc_ff == '0)
    else $error("prescale count did not wrap on a count step");
  a_read_idle_zero: assert property (!$past(take && !hwrite) |-> hrdata == '0)
    else $error("read data shown without a read");

  // Main scenarios the bench is expected to reach
  c_ch3_halt: cover property (hit[1] && halt_en[1] ##1 !count_run_flag);
  c_ch2_clear: cover property (hit[0] && clr_en[0] && !any_halt ##1 timer_count == '0);
  c_ch3_clear: cover property (hit[1] && clr_en[1] && !any_halt ##1 timer_count == '0);
  c_ch4_irq: cover property (match_irq[2]);
  c_both_armed: cover property (any_halt && |(hit & clr_en));
endmodule
`default_nettype wire

// [verif/tmac_top_bench.sv]
// Self-checking bench for the timer match action block
`timescale 1ns/100ps
`default_nettype none
`include "tmac_map.svh"

module tmac_top_bench;
  import tmac_pkg::*;
  logic clk, rst, hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic hready, hresp;
  wire logic [31:0] hrdata;
  wire logic [2:0] match_irq, cm_sel;
  wire logic [15:0] tc;
  wire logic run;
  int fail_count, cmp_count;
  int irq_n [3];
  logic [15:0] max_tc;

  tmac_top DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .match_irq(match_irq), .irq_condition_select(cm_sel), .timer_count(tc), .count_run_flag(run));

  // Free-running bench clock, 10 ns period
  always #5 clk = ~clk;

  task automatic end_of_test();
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One AHB-Lite single transfer; signals move at the edge, read data is taken where hready is seen high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask

  // Stop, zero the counts, load matches and actions, then run with a tick every cycle
  task automatic go(input logic [31:0] mc, input logic [15:0] m2, input logic [15:0] m3, input logic [15:0] m4);
    wr(`TMAC_OFF_CTRL, 32'h0000_0000);
    wr(`TMAC_OFF_CTRL, 32'h0000_0002);
    wr(`TMAC_OFF_PSLIM, 32'h0000_0000);
    wr(`TMAC_OFF_MV2, {16'h0000, m2});
    wr(`TMAC_OFF_MV3, {16'h0000, m3});
    wr(`TMAC_OFF_MV4, {16'h0000, m4});
    wr(`TMAC_OFF_MCTRL, mc);
    wr(`TMAC_OFF_CTRL, 32'h0000_0001);
    irq_n = '{0, 0, 0};
    max_tc = 16'h0000;
    repeat (40) begin
      // Seen at the edge before it updates: the values that stood through the cycle
      @(posedge clk);
      for (int i = 0; i < 3; i++) if (match_irq[i] === 1'b1) irq_n[i]++;
      if (tc > max_tc) max_tc = tc;
    end
  endtask

  // Enables start cleared, are writable, and only the channel bits stick
  task automatic t_regs();
    logic [31:0] q;
    rd(`TMAC_OFF_MCTRL, q);
    chk(q, 32'h0000_0000);
    wr(`TMAC_OFF_MCTRL, 32'hFFFF_FFFF);
    rd(`TMAC_OFF_MCTRL, q);
    chk(q, 32'h0000_7FC0);
    rd(8'h3C, q);
    chk(q, 32'h0000_0000);
    wr(`TMAC_OFF_CMSEL, 32'h0000_0005);
    rd(`TMAC_OFF_CMSEL, q);
    chk(q, 32'h0000_0005);
    chk(cm_sel, 3'h5);
    chk(hresp, `TMAC_HRESP_OKAY);
  endtask

  // Channel 4 interrupt with channel 3 clearing at the same value; channel 2 passes by unarmed
  task automatic t_irq4_clr3();
    go(32'h0000_1400, 16'h0002, 16'h0003, 16'h0003);
    chk(irq_n[2] > 0, 1);
    chk(irq_n[1], 0);
    chk(max_tc, 16'h0003);
    chk(run, 1'b1);
  endtask

  // Channel 3 interrupt without clear, channel 2 clearing one step later; channel 4 silent when disabled
  task automatic t_irq3_clr2();
    go(32'h0000_0280, 16'h0003, 16'h0002, 16'h0001);
    chk(irq_n[1] > 0, 1);
    chk(irq_n[2], 0);
    chk(max_tc, 16'h0003);
  endtask

  // Halt plus clear on one channel: count freezes at the match value and run drops
  task automatic t_halt(input logic [31:0] mc, input logic ch3);
    logic [15:0] m;
    logic [31:0] q;
    m = ch3 ? 16'h0005 : 16'h0004;
    go(mc, ch3 ? 16'h0020 : m, ch3 ? m : 16'h0020, 16'h0020);
    chk(run, 1'b0);
    chk(tc, m);
    chk(max_tc, m);
    rd(`TMAC_OFF_CTRL, q);
    chk(q, 32'h0000_0000);
    rd(`TMAC_OFF_TC, q);
    chk(q, {16'h0000, m});
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #200us;
    fail_count++;
    end_of_test();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    hsize = 3'b010;
    fail_count = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_irq4_clr3();
    t_irq3_clr2();
    t_halt(32'h0000_0C00, 1'b1);
    t_halt(32'h0000_0180, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
